//--- verilog/osct_pkg.sv
// Constants, register map and carriers of the internal oscillator select and tune block
//----------------------------------------------------------------------------
// Behaviour
//----------------------------------------------------------------------------
// Behaviour
// - RC mode drives oscillator clock over four
// - RC-with-I/O mode frees pin two as GPIO
// - Internal clock-out mode: pin one GPIO, pin two clock/4
// - Internal I/O mode: both pins GPIO, no clock
// - Fast oscillator on for nonzero select when used
// - Control bit 2 reads fast oscillator stable
// - Slow oscillator on for select zero or timers
// - Control bit 1 reads slow oscillator stable
// - Timers and monitor tick from slow oscillator
// - Five-bit signed tune value, resets to zero
// - Tune settles within 1 ms, no flag
// - Tune never alters slow oscillator timing
// - Select bits 6:4 pick one of eight clocks
// - Select resets to 110, 4 MHz, stays writable
// - One bit picks external or internal clock
// - Select bit set uses internal; clears on reset
package osct_pkg;

	//------------------------------------------------------------------------
	// Register map
	//------------------------------------------------------------------------
	localparam logic [7:0] ADDR_TUNE     = 8'h90;
	localparam logic [7:0] ADDR_CONTROL  = 8'h8C;
	localparam logic [4:0] TUNE_RESET    = 5'h00;
	localparam logic [2:0] FSEL_RESET    = 3'h6;
	localparam logic       SYSSEL_RESET  = 1'b0;
	localparam int         CTL_FSEL_LSB  = 4;
	localparam int         CTL_FAST_BIT  = 2;
	localparam int         CTL_SLOW_BIT  = 1;
	localparam int         CTL_SYSSEL_BIT = 0;
	localparam logic [2:0] FSEL_SLOW     = 3'h0;
	localparam logic [2:0] FSEL_FASTEST  = 3'h7;
	localparam int         DIVOUT_RATIO  = 4;
	localparam int         TUNE_SETTLE_US = 1000;
	localparam logic [1:0] RESP_OKAY     = 2'h0;
	localparam logic [1:0] RESP_SLVERR   = 2'h2;

	//------------------------------------------------------------------------
	// Oscillator modes held by the configuration word
	//------------------------------------------------------------------------
	typedef enum logic [2:0] {
		OSCT_MODE_LP      = 3'h0,
		OSCT_MODE_XT      = 3'h1,
		OSCT_MODE_HS      = 3'h2,
		OSCT_MODE_EC      = 3'h3,
		OSCT_MODE_INT_IO  = 3'h4,
		OSCT_MODE_INT_CLK = 3'h5,
		OSCT_MODE_RC_IO   = 3'h6,
		OSCT_MODE_RC_CLK  = 3'h7
	} osct_mode_t;

	typedef struct packed {
		logic [2:0] internal_freq_select;
		logic       system_clock_select;
	} osct_ctrl_t;

	typedef struct packed {
		logic out;
		logic oe;
	} osct_pin_t;

endpackage

//--- verilog/osct_top.sv
// Oscillator source select, postscaler, tuning register and pin muxing
`timescale 1ns/1ps
module osct_top (
	input  wire logic                aclk,              // System clock, 25 MHz
	input  wire logic                aresetn,           // Synchronous reset, active low
	input  wire logic [7:0]          s_axi_awaddr,      // Write address
	input  wire logic                s_axi_awvalid,     // Write address valid
	output logic                     s_axi_awready,     // Write address ready
	input  wire logic [31:0]         s_axi_wdata,       // Write data
	input  wire logic [3:0]          s_axi_wstrb,       // Write strobes
	input  wire logic                s_axi_wvalid,      // Write data valid
	output logic                     s_axi_wready,      // Write data ready
	output logic [1:0]               s_axi_bresp,       // Write response
	output logic                     s_axi_bvalid,      // Write response valid
	input  wire logic                s_axi_bready,      // Write response ready
	input  wire logic [7:0]          s_axi_araddr,      // Read address
	input  wire logic                s_axi_arvalid,     // Read address valid
	output logic                     s_axi_arready,     // Read address ready
	output logic [31:0]              s_axi_rdata,       // Read data
	output logic [1:0]               s_axi_rresp,       // Read response
	output logic                     s_axi_rvalid,      // Read data valid
	input  wire logic                s_axi_rready,      // Read data ready
	input  wire logic [2:0]          osc_mode,          // Configuration oscillator mode
	input  wire logic                internal_external_switchover, // Two-speed start-up
	input  wire logic                power_up_timer_en, // Power-up timer enabled
	input  wire logic                watchdog_timer_en, // Watchdog enabled
	input  wire logic                fail_safe_clock_monitor_en, // Monitor enabled
	input  wire logic                fast_internal_osc_clk, // Fast oscillator output
	input  wire logic                fast_internal_osc_ready, // Fast oscillator settled
	input  wire logic                slow_internal_osc_clk, // Slow oscillator output
	input  wire logic                slow_internal_osc_ready, // Slow oscillator settled
	input  wire logic                ext_clk_in,        // External or RC clock on pin one
	output logic                     fast_internal_osc_en, // Fast oscillator enable
	output logic                     slow_internal_osc_en, // Slow oscillator enable
	output logic [4:0]               fast_osc_trim,     // Tune code to fast oscillator
	output logic                     sys_clk_tick,      // System clock enable pulse
	output logic                     timer_tick,        // Slow tick for timers and monitor
	input  wire logic                osc_pin_one_in,    // Pin one level
	output logic                     osc_pin_one_out,   // Pin one drive
	output logic                     osc_pin_one_oe,    // Pin one drive enable
	input  wire logic                osc_pin_two_in,    // Pin two level
	output logic                     osc_pin_two_out,   // Pin two drive
	output logic                     osc_pin_two_oe,    // Pin two drive enable
	input  wire logic                gpio_one_out,      // Port drive for pin one
	input  wire logic                gpio_one_oe,       // Port enable for pin one
	input  wire logic                port_a_bit_four_out, // Port drive for pin two
	input  wire logic                port_a_bit_four_oe,  // Port enable for pin two
	output logic                     gpio_one_in,       // Pin one level to port
	output logic                     port_a_bit_four_in // Pin two level to port
);

	//------------------------------------------------------------------------
	// Input synchronisers and edge detect
	//------------------------------------------------------------------------
	localparam int NSYNC = 7;
	logic [NSYNC-1:0] sync1_r;
	logic [NSYNC-1:0] sync2_r;
	logic [2:0]       clk_last_r;
	logic             fast_edge;
	logic             slow_edge;
	logic             ext_edge;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync1_r    <= '0;
			sync2_r    <= '0;
			clk_last_r <= '0;
		end else begin
			sync1_r    <= {osc_pin_two_in, osc_pin_one_in, ext_clk_in, slow_internal_osc_ready,
				slow_internal_osc_clk, fast_internal_osc_ready, fast_internal_osc_clk};
			sync2_r    <= sync1_r;
			clk_last_r <= {sync2_r[4], sync2_r[2], sync2_r[0]};
		end
	end

	assign fast_edge          = sync2_r[0] & ~clk_last_r[0];
	assign slow_edge          = sync2_r[2] & ~clk_last_r[1];
	assign ext_edge           = sync2_r[4] & ~clk_last_r[2];
	assign gpio_one_in        = sync2_r[5];
	assign port_a_bit_four_in = sync2_r[6];

	//------------------------------------------------------------------------
	// Registers
	//------------------------------------------------------------------------
	osct_pkg::osct_ctrl_t ctrl_r;
	logic [4:0]           tune_r;
	osct_pkg::osct_mode_t mode;

	assign mode = osct_pkg::osct_mode_t'(osc_mode);

	function automatic logic is_internal_mode(input osct_pkg::osct_mode_t m);
		return (m == osct_pkg::OSCT_MODE_INT_IO) || (m == osct_pkg::OSCT_MODE_INT_CLK);
	endfunction

	function automatic logic is_rc_mode(input osct_pkg::osct_mode_t m);
		return (m == osct_pkg::OSCT_MODE_RC_IO) || (m == osct_pkg::OSCT_MODE_RC_CLK);
	endfunction

	//------------------------------------------------------------------------
	// AXI4-Lite slave
	//------------------------------------------------------------------------
	logic        aw_have_r;
	logic        w_have_r;
	logic [7:0]  aw_addr_r;
	logic [31:0] w_data_r;
	logic [3:0]  w_strb_r;
	logic        wr_go;
	logic [31:0] rd_word;
	logic        rd_hit;

	assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
	assign s_axi_wready  = !w_have_r && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign wr_go         = aw_have_r && w_have_r && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_r <= 1'b0;
			w_have_r  <= 1'b0;
			aw_addr_r <= 8'h00;
			w_data_r  <= 32'h0000_0000;
			w_strb_r  <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end else if (wr_go) begin
				aw_have_r <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end else if (wr_go) begin
				w_have_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= osct_pkg::RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (aw_addr_r == osct_pkg::ADDR_TUNE || aw_addr_r == osct_pkg::ADDR_CONTROL)
				? osct_pkg::RESP_OKAY : osct_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Tune register: only the low five bits are stored
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tune_r <= osct_pkg::TUNE_RESET;
		end else if (wr_go && aw_addr_r == osct_pkg::ADDR_TUNE && w_strb_r[0]) begin
			tune_r <= w_data_r[4:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_r.internal_freq_select <= osct_pkg::FSEL_RESET;
			ctrl_r.system_clock_select  <= osct_pkg::SYSSEL_RESET;
		end else if (wr_go && aw_addr_r == osct_pkg::ADDR_CONTROL && w_strb_r[0]) begin
			ctrl_r.internal_freq_select <= w_data_r[osct_pkg::CTL_FSEL_LSB +: 3];
			ctrl_r.system_clock_select  <= w_data_r[osct_pkg::CTL_SYSSEL_BIT];
		end
	end

	always_comb begin
		rd_word = 32'h0000_0000;
		rd_hit  = 1'b1;
		unique case (s_axi_araddr)
			osct_pkg::ADDR_TUNE: begin
				rd_word[4:0] = tune_r;
			end
			osct_pkg::ADDR_CONTROL: begin
				rd_word[osct_pkg::CTL_FSEL_LSB +: 3] = ctrl_r.internal_freq_select;
				rd_word[osct_pkg::CTL_FAST_BIT]      = sync2_r[1];
				rd_word[osct_pkg::CTL_SLOW_BIT]      = sync2_r[3];
				rd_word[osct_pkg::CTL_SYSSEL_BIT]    = ctrl_r.system_clock_select;
			end
			default: begin
				rd_hit = 1'b0;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= osct_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_word;
			s_axi_rresp  <= rd_hit ? osct_pkg::RESP_OKAY : osct_pkg::RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	//------------------------------------------------------------------------
	// Oscillator enables and trim
	//------------------------------------------------------------------------
	logic use_internal;
	logic fsel_slow;

	assign use_internal = ctrl_r.system_clock_select || is_internal_mode(mode);
	assign fsel_slow    = ctrl_r.internal_freq_select == osct_pkg::FSEL_SLOW;

	assign fast_internal_osc_en = !fsel_slow && (use_internal || internal_external_switchover);
	assign slow_internal_osc_en = (fsel_slow && (use_internal || internal_external_switchover))
		|| power_up_timer_en || watchdog_timer_en || fail_safe_clock_monitor_en;

	// Trim goes straight to the oscillator; it slews over up to 1 ms and raises no flag
	assign fast_osc_trim = tune_r;

	//------------------------------------------------------------------------
	// Postscaler and source multiplexer
	//------------------------------------------------------------------------
	logic [6:0] post_cnt_r;
	logic       int_tick;
	logic       src_tick;

	function automatic logic post_hit(input logic [6:0] cnt, input logic [2:0] fsel);
		logic [6:0] mask;
		mask = 7'h7F >> fsel;
		return (cnt & mask) == mask;
	endfunction

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			post_cnt_r <= 7'h00;
		end else if (fast_edge) begin
			post_cnt_r <= post_cnt_r + 7'h01;
		end
	end

	// 111 passes every fast edge, each lower code halves, 000 takes the slow oscillator
	assign int_tick = fsel_slow ? slow_edge
		: (fast_edge && post_hit(post_cnt_r, ctrl_r.internal_freq_select));
	assign src_tick = use_internal ? int_tick : ext_edge;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sys_clk_tick <= 1'b0;
			timer_tick   <= 1'b0;
		end else begin
			sys_clk_tick <= src_tick;
			timer_tick   <= slow_edge;
		end
	end

	//------------------------------------------------------------------------
	// Divided clock out and pin muxing
	//------------------------------------------------------------------------
	logic      div_half_r;
	logic      divout_r;
	logic      divout_mode;
	logic      pin_one_gpio;
	osct_pkg::osct_pin_t pin_two;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_half_r <= 1'b0;
			divout_r   <= 1'b0;
		end else if (src_tick) begin
			div_half_r <= !div_half_r;
			if (div_half_r) begin
				divout_r <= !divout_r;
			end
		end
	end

	assign divout_mode  = (mode == osct_pkg::OSCT_MODE_RC_CLK)
		|| (mode == osct_pkg::OSCT_MODE_INT_CLK);
	assign pin_one_gpio = is_internal_mode(mode);

	always_comb begin
		pin_two.out = 1'b0;
		pin_two.oe  = 1'b0;
		if (divout_mode) begin
			pin_two.out = divout_r;
			pin_two.oe  = 1'b1;
		end else if (mode == osct_pkg::OSCT_MODE_RC_IO || is_internal_mode(mode)
			|| mode == osct_pkg::OSCT_MODE_EC) begin
			pin_two.out = port_a_bit_four_out;
			pin_two.oe  = port_a_bit_four_oe;
		end
	end

	assign osc_pin_two_out = pin_two.out;
	assign osc_pin_two_oe  = pin_two.oe;
	assign osc_pin_one_out = pin_one_gpio ? gpio_one_out : 1'b0;
	assign osc_pin_one_oe  = pin_one_gpio ? gpio_one_oe : 1'b0;

	//------------------------------------------------------------------------
	// Assertions
	//------------------------------------------------------------------------
	sequence s_tune_write;
		wr_go && aw_addr_r == osct_pkg::ADDR_TUNE && w_strb_r[0];
	endsequence

	sequence s_ctrl_write;
		wr_go && aw_addr_r == osct_pkg::ADDR_CONTROL && w_strb_r[0];
	endsequence

	property p_reset_values;
		@(posedge aclk) !aresetn |=> tune_r == osct_pkg::TUNE_RESET
			&& ctrl_r.internal_freq_select == osct_pkg::FSEL_RESET
			&& ctrl_r.system_clock_select == osct_pkg::SYSSEL_RESET;
	endproperty
	a_reset_values: assert property (p_reset_values) else $error("bad reset values");

	property p_tune_store;
		logic [4:0] v;
		@(posedge aclk) disable iff (!aresetn)
			(s_tune_write, v = w_data_r[4:0]) |=> fast_osc_trim == v;
	endproperty
	a_tune_store: assert property (p_tune_store) else $error("tune not stored");

	property p_tune_read_high;
		@(posedge aclk) disable iff (!aresetn)
			s_axi_arvalid && s_axi_arready && s_axi_araddr == osct_pkg::ADDR_TUNE
			|=> s_axi_rdata[31:5] == 27'h0 && s_axi_rvalid;
	endproperty
	a_tune_read_high: assert property (p_tune_read_high) else $error("tune high bits set");

	property p_fsel_write;
		logic [2:0] v;
		@(posedge aclk) disable iff (!aresetn)
			(s_ctrl_write, v = w_data_r[6:4]) |=> ctrl_r.internal_freq_select == v;
	endproperty
	a_fsel_write: assert property (p_fsel_write) else $error("select not written");

	property p_fast_en;
		@(posedge aclk) disable iff (!aresetn)
			ctrl_r.system_clock_select && ctrl_r.internal_freq_select != 3'h0 |-> fast_internal_osc_en;
	endproperty
	a_fast_en: assert property (p_fast_en) else $error("fast osc not enabled");

	property p_slow_en;
		@(posedge aclk) disable iff (!aresetn)
			watchdog_timer_en || (ctrl_r.system_clock_select && ctrl_r.internal_freq_select == 3'h0)
			|-> slow_internal_osc_en && !(fsel_slow && fast_internal_osc_en);
	endproperty
	a_slow_en: assert property (p_slow_en) else $error("slow osc not enabled");

	property p_timer_tick;
		@(posedge aclk) disable iff (!aresetn) slow_edge |=> timer_tick;
	endproperty
	a_timer_tick: assert property (p_timer_tick) else $error("timer tick lost");

	property p_divout_div;
		@(posedge aclk) disable iff (!aresetn)
			$changed(divout_r) |-> $past(div_half_r) && $past(src_tick);
	endproperty
	a_divout_div: assert property (p_divout_div) else $error("clock out not over four");

	property p_io_pins;
		@(posedge aclk) disable iff (!aresetn)
			mode == osct_pkg::OSCT_MODE_INT_IO |-> osc_pin_two_oe == port_a_bit_four_oe
			&& osc_pin_one_oe == gpio_one_oe;
	endproperty
	a_io_pins: assert property (p_io_pins) else $error("pins not released");

	property p_divout_pin;
		@(posedge aclk) disable iff (!aresetn)
			divout_mode |-> osc_pin_two_oe && osc_pin_two_out == divout_r;
	endproperty
	a_divout_pin: assert property (p_divout_pin) else $error("clock out not driven");

endmodule // osct_top

//--- dv/tb.sv
// Self-checking testbench for the oscillator select and tune block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin num_errors++; $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module tb;
	//------------------------------------------------------------------------
	// Stimulus and observed signals
	//------------------------------------------------------------------------
	logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, swover = 0, pu_tmr_en = 0, wdog_en = 0, mon_en = 0;
	logic fclk = 0, fast_rdy = 1, sclk = 0, slow_rdy = 0, eclk = 0, p1_in = 0, p2_in = 0;
	logic g1_out = 0, g1_oe = 0, pa4_out = 0, pa4_oe = 0;
	logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0;
	logic [3:0]  s_axi_wstrb = 0;
	logic [2:0]  osc_mode = 0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
	logic [31:0] s_axi_rdata, rdat;
	logic        fast_en, slow_en, sys_tick, tmr_tick, p1_out, p1_oe, p2_out, p2_oe, g1_in, pa4_in;
	logic [4:0]  trim;
	int          num_errors = 0, checked = 0, cnt = 0, p;

	osct_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .osc_mode(osc_mode), .internal_external_switchover(swover),
		.power_up_timer_en(pu_tmr_en), .watchdog_timer_en(wdog_en),
		.fail_safe_clock_monitor_en(mon_en), .fast_internal_osc_clk(fclk),
		.fast_internal_osc_ready(fast_rdy), .slow_internal_osc_clk(sclk),
		.slow_internal_osc_ready(slow_rdy), .ext_clk_in(eclk), .fast_internal_osc_en(fast_en),
		.slow_internal_osc_en(slow_en), .fast_osc_trim(trim), .sys_clk_tick(sys_tick),
		.timer_tick(tmr_tick), .osc_pin_one_in(p1_in), .osc_pin_one_out(p1_out),
		.osc_pin_one_oe(p1_oe), .osc_pin_two_in(p2_in), .osc_pin_two_out(p2_out),
		.osc_pin_two_oe(p2_oe), .gpio_one_out(g1_out), .gpio_one_oe(g1_oe),
		.port_a_bit_four_out(pa4_out), .port_a_bit_four_oe(pa4_oe), .gpio_one_in(g1_in),
		.port_a_bit_four_in(pa4_in));

	//------------------------------------------------------------------------
	// Clock and free-running oscillator waveforms
	//------------------------------------------------------------------------
	always #20 aclk = ~aclk;
	// Fast and external periods 4 cycles, slow period 12 cycles
	always @(posedge aclk) begin
		cnt <= cnt + 1;
		if (cnt % 2 == 1) fclk <= ~fclk;
		if (cnt % 2 == 0) eclk <= ~eclk;
		if (cnt % 6 == 5) sclk <= ~sclk;
	end

	//------------------------------------------------------------------------
	// Bus tasks and helpers
	//------------------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] st);
		logic ta, tw, tb_;
		int n;
		tb_ = 0;
		n = 0;
		s_axi_awaddr <= a; s_axi_awvalid <= 1'b1; s_axi_wdata <= d;
		s_axi_wstrb <= st; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
		while (!tb_ && n < 100) begin
			@(negedge aclk);
			ta = s_axi_awvalid & s_axi_awready;
			tw = s_axi_wvalid & s_axi_wready;
			tb_ = s_axi_bvalid;
			rsp = s_axi_bresp;
			@(posedge aclk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			n++;
		end
		s_axi_bready <= 1'b0;
		@(posedge aclk);
		`CHK("write answered", 1'b1, tb_)
	endtask

	task automatic rd(input logic [7:0] a);
		logic tr, ta;
		int n;
		tr = 0;
		ta = 0;
		n = 0;
		s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
		while (!tr && n < 100) begin
			@(negedge aclk);
			ta = s_axi_arvalid & s_axi_arready;
			tr = s_axi_rvalid;
			rdat = s_axi_rdata;
			rsp = s_axi_rresp;
			@(posedge aclk);
			if (ta) s_axi_arvalid <= 1'b0;
			n++;
		end
		s_axi_rready <= 1'b0;
		@(posedge aclk);
		`CHK("read answered", 1'b1, tr)
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		rd(a);
		`CHK("read data", e, rdat)
		`CHK("read resp", er, rsp)
	endtask

	function automatic logic [31:0] ctl(logic [2:0] f, logic fs, logic sl, logic sc);
		return (32'(f) << osct_pkg::CTL_FSEL_LSB) | (32'(fs) << osct_pkg::CTL_FAST_BIT)
			| (32'(sl) << osct_pkg::CTL_SLOW_BIT) | 32'(sc);
	endfunction

	// Cycles between two rising edges of a tick or pin, skipping the first one
	task automatic period(input int sel, output int q);
		logic pv, cv;
		int r, n;
		pv = 1; r = 0; q = 0; n = 0;
		while (r < 3 && n < 3000) begin
			@(negedge aclk);
			cv = (sel == 0) ? sys_tick : (sel == 1) ? tmr_tick : p2_out;
			if (!pv && cv) r++;
			if (r == 2) q++;
			pv = cv;
			n++;
		end
		@(posedge aclk);
	endtask

	//------------------------------------------------------------------------
	// Scenarios
	//------------------------------------------------------------------------
	task automatic t_reset();
		rchk(osct_pkg::ADDR_TUNE, 32'h0, osct_pkg::RESP_OKAY);
		rchk(osct_pkg::ADDR_CONTROL, ctl(3'h6, 1'b1, 1'b0, 1'b0), osct_pkg::RESP_OKAY);
		fast_rdy <= 1'b0; slow_rdy <= 1'b1;
		repeat (4) @(posedge aclk);
		rchk(osct_pkg::ADDR_CONTROL, ctl(3'h6, 1'b0, 1'b1, 1'b0), osct_pkg::RESP_OKAY);
		`CHK("trim at reset", 5'h00, trim)
		$display("test reset done");
	endtask

	task automatic t_regs();
		wr(osct_pkg::ADDR_TUNE, 32'h0000_00FF, 4'hF);
		rchk(osct_pkg::ADDR_TUNE, 32'h1F, osct_pkg::RESP_OKAY);
		`CHK("trim follows at once", 5'h1F, trim)
		wr(osct_pkg::ADDR_TUNE, 32'h10, 4'hE);
		`CHK("masked write resp", osct_pkg::RESP_OKAY, rsp)
		rchk(osct_pkg::ADDR_TUNE, 32'h1F, osct_pkg::RESP_OKAY);
		wr(8'h94, 32'h0, 4'hF);
		`CHK("unmapped write resp", osct_pkg::RESP_SLVERR, rsp)
		rchk(8'h94, 32'h0, osct_pkg::RESP_SLVERR);
		wr(osct_pkg::ADDR_CONTROL, 32'hFF, 4'hF);
		rchk(osct_pkg::ADDR_CONTROL, ctl(3'h7, 1'b0, 1'b1, 1'b1), osct_pkg::RESP_OKAY);
		rchk(osct_pkg::ADDR_TUNE, 32'h1F, osct_pkg::RESP_OKAY);
		$display("test registers done");
	endtask

	// Entry: mode, select bit, switchover, freq select, timers, fast and slow enables
	localparam logic [12:0] EN_TAB [9] = '{13'b100_0_0_000_000_0_1, 13'b100_0_0_111_000_1_0,
		13'b000_1_0_011_000_1_0, 13'b000_0_0_011_000_0_0, 13'b000_0_1_011_000_1_0,
		13'b000_0_1_000_000_0_1, 13'b000_0_0_011_001_0_1, 13'b000_0_0_011_010_0_1,
		13'b000_0_0_011_100_0_1};

	task automatic t_enables();
		logic [12:0] e;
		for (int i = 0; i < 9; i++) begin
			e = EN_TAB[i];
			osc_mode <= e[12:10]; swover <= e[8];
			{pu_tmr_en, wdog_en, mon_en} <= e[4:2];
			wr(osct_pkg::ADDR_CONTROL, 32'({e[7:5], 3'h0, e[9]}), 4'hF);
			@(negedge aclk);
			`CHK("fast enable", e[1], fast_en)
			`CHK("slow enable", e[0], slow_en)
			@(posedge aclk);
		end
		swover <= 1'b0; {pu_tmr_en, wdog_en, mon_en} <= 3'h0;
		$display("test enables done");
	endtask

	task automatic t_clocks();
		osc_mode <= osct_pkg::OSCT_MODE_LP;
		for (int c = 7; c >= 0; c--) begin
			wr(osct_pkg::ADDR_CONTROL, 32'({3'(c), 4'h1}), 4'hF);
			period(0, p);
			`CHK("system tick period", (c == 0) ? 12 : (4 << (7 - c)), p)
		end
		osc_mode <= osct_pkg::OSCT_MODE_RC_CLK;
		wr(osct_pkg::ADDR_CONTROL, 32'h60, 4'hF);
		period(0, p);
		`CHK("external tick period", 4, p)
		period(2, p);
		`CHK("rc clock out period", 16, p)
		period(1, p);
		`CHK("timer tick period", 12, p)
		wr(osct_pkg::ADDR_TUNE, 32'h10, 4'hF);
		`CHK("trim minimum", 5'h10, trim)
		period(1, p);
		`CHK("timer tick after tune", 12, p)
		osc_mode <= osct_pkg::OSCT_MODE_INT_CLK;
		period(2, p);
		`CHK("internal clock out period", 32, p)
		$display("test clocks done");
	endtask

	task automatic t_pins();
		g1_out <= 1'b1; g1_oe <= 1'b1; pa4_out <= 1'b1; pa4_oe <= 1'b1; p2_in <= 1'b1;
		osc_mode <= osct_pkg::OSCT_MODE_RC_IO;
		@(negedge aclk);
		`CHK("rc io pin two oe", 1'b1, p2_oe)
		`CHK("rc io pin two out", 1'b1, p2_out)
		`CHK("rc io pin one oe", 1'b0, p1_oe)
		@(posedge aclk);
		osc_mode <= osct_pkg::OSCT_MODE_RC_CLK;
		@(negedge aclk);
		`CHK("rc pin two oe", 1'b1, p2_oe)
		`CHK("rc pin one oe", 1'b0, p1_oe)
		@(posedge aclk);
		osc_mode <= osct_pkg::OSCT_MODE_INT_CLK;
		@(negedge aclk);
		`CHK("int clk pin one oe", 1'b1, p1_oe)
		`CHK("int clk pin one out", 1'b1, p1_out)
		`CHK("int clk pin two oe", 1'b1, p2_oe)
		@(posedge aclk);
		osc_mode <= osct_pkg::OSCT_MODE_INT_IO; pa4_oe <= 1'b0; p1_in <= 1'b1;
		repeat (4) @(posedge aclk);
		@(negedge aclk);
		`CHK("int io pin two oe", 1'b0, p2_oe)
		`CHK("int io pin one out", 1'b1, p1_out)
		`CHK("pin two level in", 1'b1, pa4_in)
		`CHK("pin one level in", 1'b1, g1_in)
		@(posedge aclk);
		$display("test pins done");
	endtask

	//------------------------------------------------------------------------
	// Verdict, watchdog and main sequence
	//------------------------------------------------------------------------
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial begin
		repeat (40000) @(posedge aclk);
		num_errors++;
		stop_test();
	end

	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_reset();
		t_regs();
		t_enables();
		t_clocks();
		t_pins();
		stop_test();
	end
endmodule // tb
